// file: psp_defines.svh
// Purpose: constants of the pipelined synchronous memory port
// Assumes: included by the package and by every design file
// Notes: organisation figures, lane width, burst width, reset values
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH
`define PSP_LANE_W 9
`define PSP_MAX_LANES 8
`define PSP_BURST_W 2
`define PSP_ADDR_W_X36 20
`define PSP_DATA_W_X36 36
`define PSP_ADDR_W_X18 21
`define PSP_DATA_W_X18 18
`define PSP_ADDR_W_X72 19
`define PSP_DATA_W_X72 72
`define PSP_RST_DRIVE 1'b0
`define PSP_RST_SLEEP 1'b0
`define PSP_RST_BURST 2'h0
`endif

// file: psp_host_model.sv
// Purpose: controller-side model of the shared data wire
// Assumes: host_en is raised only in the data phase of the controller's own writes
// Notes: an undriven wire shows the inverse of its last driven level
module psp_host_model #(
  parameter int DW = 36
) (
  // device side
  input wire logic [DW-1:0] dq_out,
  input wire logic dq_oe_n,
  // controller side
  input wire logic [DW-1:0] host_d,
  input wire logic host_en,
  // resolved wire
  output logic [DW-1:0] dq_in,
  output logic clash
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DW-1:0] last_lvl = '0;
  ////////////////////////////////////////////////////////////////
  // wire resolution, no stale level on a released bus
  always @* begin
    clash = host_en && !dq_oe_n;
    if (host_en) dq_in = host_d;
    else if (!dq_oe_n) dq_in = dq_out;
    else dq_in = ~last_lvl;
  end
  always @(dq_in) if (host_en || !dq_oe_n) last_lvl = dq_in;
endmodule : psp_host_model

// file: psp_mem.sv
// Purpose: storage array with byte-lane write and registered read
// Assumes: one write port and one read port on ref_clk
// Notes: same-address same-edge read returns the newly written lanes
`include "psp_defines.svh"
module psp_mem #(
  parameter int AW = `PSP_ADDR_W_X36,
  parameter int DW = `PSP_DATA_W_X36,
  parameter int LW = `PSP_LANE_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_ff,
  // write port
  input wire logic [DW/LW-1:0] we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata
);
  localparam int NL = DW / LW;
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] nxt_rdata;
  logic [DW-1:0] cur;

  ////////////////////////////////////////////////////////////
  // write-first read with per-lane bypass
  always_comb begin
    cur = mem[raddr];
    nxt_rdata = rdata_ff;
    if (rd_en) begin
      for (int i = 0; i < NL; i++) begin
        nxt_rdata[i*LW +: LW] = (we[i] && waddr == raddr) ? wdata[i*LW +: LW] : cur[i*LW +: LW];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////
  // self-timed lane writes
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NL; i++) begin
      if (we[i]) begin
        mem[waddr][i*LW +: LW] <= wdata[i*LW +: LW];
      end
    end
  end
endmodule : psp_mem

// file: psp_pkg.sv
// Purpose: shared types of the memory port
// Assumes: psp_defines.svh is on the include path
// Notes: cycle kinds travel with the captured byte selects
`include "psp_defines.svh"
package psp_pkg;
  typedef enum logic [1:0] {PSP_NOP, PSP_RD, PSP_WR} psp_cyc_t;
  typedef struct packed {
    psp_cyc_t kind;
    logic [`PSP_MAX_LANES-1:0] be_n;
  } psp_ctl_t;
endpackage : psp_pkg

// file: psp_top.sv
// Purpose: pipelined burst memory port with byte writes and no turnaround
// Assumes: controller inputs synchronous to ref_clk; dq wire resolved outside
// Notes: address at edge 0, read data out after edge 1, write data at edge 2
`include "psp_defines.svh"
module psp_top
  import psp_pkg::*;
#(
  parameter int AW = `PSP_ADDR_W_X36,
  parameter int DW = `PSP_DATA_W_X36
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // address and control
  input wire logic [AW-1:0] addr,
  input wire logic burst_advance,
  input wire logic write_strobe_n,
  input wire logic [DW/`PSP_LANE_W-1:0] byte_lane_write_select_n,
  input wire logic clock_qualifier_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic output_enable_n,
  input wire logic burst_order,
  input wire logic sleep_request,
  // data pins
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_n,
  // status
  output logic sleep_active
);
  localparam int NL = DW / `PSP_LANE_W;

  ////////////////////////////////////////////////////////////
  // decoders
  function automatic logic cs_decode(input logic c1_n, input logic c2, input logic c3_n);
    cs_decode = !c1_n && c2 && !c3_n;
  endfunction : cs_decode

  function automatic logic [`PSP_BURST_W-1:0] burst_low(input logic [`PSP_BURST_W-1:0] start,
                                                      input logic [`PSP_BURST_W-1:0] step,
                                                      input logic inter);
    burst_low = inter ? (start ^ step) : `PSP_BURST_W'(start + step);
  endfunction : burst_low

  ////////////////////////////////////////////////////////////
  // state
  logic en;
  logic sel;
  psp_ctl_t s1_ff, nxt_s1;
  psp_ctl_t s2_ff, nxt_s2;
  logic [AW-1:0] s1_addr_ff, nxt_s1_addr;
  logic [AW-1:0] s2_addr_ff, nxt_s2_addr;
  logic [`PSP_BURST_W-1:0] base_lo_ff, nxt_base_lo;
  logic [`PSP_BURST_W-1:0] cnt_ff, nxt_cnt;
  logic [`PSP_BURST_W-1:0] step;
  logic drive_ff, nxt_drive;
  logic sleep_ff, nxt_sleep;
  logic rd_go;
  logic wr_go;
  logic [NL-1:0] mem_we;

  assign en = !clock_qualifier_n;
  assign sel = cs_decode(chip_select_first_n, chip_select_second, chip_select_third_n);
  assign step = `PSP_BURST_W'(cnt_ff + `PSP_BURST_W'(1));

  ////////////////////////////////////////////////////////////
  // input stage: load, burst advance, deselect
  always_comb begin
    nxt_s1 = s1_ff;
    nxt_s1_addr = s1_addr_ff;
    nxt_base_lo = base_lo_ff;
    nxt_cnt = cnt_ff;
    if (en) begin
      nxt_s1.be_n = '1;
      nxt_s1.be_n[NL-1:0] = byte_lane_write_select_n;
      if (sleep_request) begin
        nxt_s1.kind = PSP_NOP;
      end else if (!burst_advance) begin
        nxt_cnt = `PSP_RST_BURST;
        nxt_s1_addr = addr;
        nxt_base_lo = addr[`PSP_BURST_W-1:0];
        nxt_s1.kind = !sel ? PSP_NOP : (write_strobe_n ? PSP_RD : PSP_WR);
      end else begin
        nxt_cnt = step;
        nxt_s1_addr[`PSP_BURST_W-1:0] = burst_low(base_lo_ff, step, burst_order);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= '{kind: PSP_NOP, be_n: '1};
      s1_addr_ff <= '0;
      base_lo_ff <= `PSP_RST_BURST;
      cnt_ff <= `PSP_RST_BURST;
    end else begin
      s1_ff <= nxt_s1;
      s1_addr_ff <= nxt_s1_addr;
      base_lo_ff <= nxt_base_lo;
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////
  // second stage: write waits for its data phase
  always_comb begin
    nxt_s2 = s2_ff;
    nxt_s2_addr = s2_addr_ff;
    if (en) begin
      nxt_s2 = s1_ff;
      nxt_s2_addr = s1_addr_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s2_ff <= '{kind: PSP_NOP, be_n: '1};
      s2_addr_ff <= '0;
    end else begin
      s2_ff <= nxt_s2;
      s2_addr_ff <= nxt_s2_addr;
    end
  end

  ////////////////////////////////////////////////////////////
  // array access
  assign rd_go = en && s1_ff.kind == PSP_RD;
  assign wr_go = en && s2_ff.kind == PSP_WR;

  for (genvar g = 0; g < NL; g++) begin : g_lane
    assign mem_we[g] = wr_go && !s2_ff.be_n[g];
  end

  psp_mem #(
    .AW(AW),
    .DW(DW),
    .LW(`PSP_LANE_W)
  ) u_mem (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rd_en(rd_go),
    .raddr(s1_addr_ff),
    .rdata_ff(dq_out),
    .we(mem_we),
    .waddr(s2_addr_ff),
    .wdata(dq_in)
  );

  ////////////////////////////////////////////////////////////
  // output drive and sleep
  always_comb begin
    nxt_drive = drive_ff;
    if (en) begin
      nxt_drive = rd_go;
    end
    nxt_sleep = sleep_request;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      drive_ff <= `PSP_RST_DRIVE;
      sleep_ff <= `PSP_RST_SLEEP;
    end else begin
      drive_ff <= nxt_drive;
      sleep_ff <= nxt_sleep;
    end
  end

  // output enable gates the drivers without the clock
  assign dq_oe_n = !drive_ff || output_enable_n || sleep_request;
  assign sleep_active = sleep_ff;

  ////////////////////////////////////////////////////////////
  // checks
  sequence s_load(logic is_sel);
    en && !sleep_request && !burst_advance && (is_sel == sel);
  endsequence

  sequence s_rd_issue;
    en && !sleep_request && !burst_advance && sel && write_strobe_n;
  endsequence

  sequence s_wr_issue;
    en && !sleep_request && !burst_advance && sel && !write_strobe_n;
  endsequence

  property p_in_cap;
    @(posedge ref_clk) disable iff (!nrst)
      s_load(1'b1) |=> s1_ff.kind != PSP_NOP && s1_addr_ff == $past(addr);
  endproperty
  a_in_cap: assert property (p_in_cap) else $error("selected load not captured");

  property p_desel;
    @(posedge ref_clk) disable iff (!nrst)
      s_load(1'b0) |=> s1_ff.kind == PSP_NOP;
  endproperty
  a_desel: assert property (p_desel) else $error("deselected cycle became active");

  property p_rd_lat;
    @(posedge ref_clk) disable iff (!nrst)
      s_rd_issue ##1 en |=> drive_ff;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data not driven on time");

  property p_rd_data;
    @(posedge ref_clk) disable iff (!nrst)
      rd_go |=> dq_out == $past(u_mem.nxt_rdata);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("output register missed read data");

  property p_wr_commit;
    @(posedge ref_clk) disable iff (!nrst)
      s_wr_issue ##1 en ##1 en |-> mem_we == ~s2_ff.be_n[NL-1:0];
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("write lanes not committed");

  property p_wr_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      s_wr_issue ##1 en |=> dq_oe_n;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("drivers on during write data");

  property p_stall;
    @(posedge ref_clk) disable iff (!nrst)
      !en |-> mem_we == '0 ##1 ($stable(dq_out) && $stable(drive_ff) && $stable(s1_addr_ff) && $stable(s2_ff));
  endproperty
  a_stall: assert property (p_stall) else $error("state moved on a stalled edge");

  property p_oe;
    @(posedge ref_clk) disable iff (!nrst)
      (output_enable_n || sleep_request) |-> dq_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("drivers on while disabled");

  property p_burst_lin;
    @(posedge ref_clk) disable iff (!nrst)
      en && burst_advance && !burst_order && !sleep_request |=>
        s1_addr_ff[AW-1:`PSP_BURST_W] == $past(s1_addr_ff[AW-1:`PSP_BURST_W]) &&
        s1_addr_ff[`PSP_BURST_W-1:0] == `PSP_BURST_W'($past(s1_addr_ff[`PSP_BURST_W-1:0]) + 1'b1);
  endproperty
  a_burst_lin: assert property (p_burst_lin) else $error("linear burst step wrong");

  property p_burst_int;
    @(posedge ref_clk) disable iff (!nrst)
      en && burst_advance && burst_order && !sleep_request |=>
        s1_addr_ff[`PSP_BURST_W-1:0] == ($past(base_lo_ff) ^ $past(step));
  endproperty
  a_burst_int: assert property (p_burst_int) else $error("interleaved burst step wrong");

  property p_b2b;
    @(posedge ref_clk) disable iff (!nrst)
      s_rd_issue ##1 s_wr_issue ##1 en |-> drive_ff ##1 dq_oe_n;
  endproperty
  a_b2b: assert property (p_b2b) else $error("read then write not back to back");

  property p_sleep;
    @(posedge ref_clk) disable iff (!nrst)
      en && sleep_request |=> s1_ff.kind == PSP_NOP && sleep_active;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not block new cycles");
endmodule : psp_top

// file: testbench.sv
// Purpose: self-checking bench of the pipelined memory port
// Assumes: inputs change on the falling edge; address width cut to 8
// Notes: a shadow pipeline predicts read data, drive enables and burst addresses
module testbench
  import psp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = 8;
  localparam int DW = 36;
  logic ref_clk = 0, nrst = 0, adv = 0, ws_n = 1, qual_n = 0, cs1_n = 0, cs2 = 1, cs3_n = 0;
  logic oe_n = 0, order = 0, sleep = 0, host_en = 0, sl_q = 0, dq_oe_n, sleep_active, clash;
  logic [AW-1:0] addr = '0, base = '0;
  logic [3:0] be_n = 4'h0;
  logic [8:0] tag9 = 9'h0a5;
  logic [1:0] k = 2'h0;
  logic [DW-1:0] dq_in, dq_out, host_d = '0, cur_d = '0;
  logic [DW-1:0] mem [0:255];
  psp_cyc_t hk [2] = '{PSP_NOP, PSP_NOP};
  psp_cyc_t last_k = PSP_NOP;
  logic [AW-1:0] ha [2];
  logic [3:0] hb [2];
  logic [DW-1:0] hd [2];
  int failures = 0, tests_run = 0;
  ////////////////////////////////////////////////////////////////
  psp_top #(.AW(AW), .DW(DW)) DUT (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .burst_advance(adv),
    .write_strobe_n(ws_n), .byte_lane_write_select_n(be_n), .clock_qualifier_n(qual_n),
    .chip_select_first_n(cs1_n), .chip_select_second(cs2), .chip_select_third_n(cs3_n),
    .output_enable_n(oe_n), .burst_order(order), .sleep_request(sleep), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .sleep_active(sleep_active));
  psp_host_model #(.DW(DW)) host (.dq_out(dq_out), .dq_oe_n(dq_oe_n), .host_d(host_d),
    .host_en(host_en), .dq_in(dq_in), .clash(clash));
  initial forever #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // one address cycle: write flag, address, lanes, advance, selects, stall
  task automatic issue(input logic wr, input logic [AW-1:0] a, input logic [3:0] be,
                       input logic b = 0, input logic [2:0] s = 3'b010, input logic q = 0);
    @(negedge ref_clk);
    ws_n = !wr;
    addr = a;
    be_n = be;
    adv = b;
    {cs1_n, cs2, cs3_n} = s;
    qual_n = q;
    cur_d = {4{tag9 ^ {1'b0, a}}};
  endtask : issue
  ////////////////////////////////////////////////////////////////
  // shadow pipeline, advanced only on enabled edges
  always @(posedge ref_clk) begin
    sl_q = nrst & sleep;
    if (!nrst) begin
      hk[0] = PSP_NOP;
      hk[1] = PSP_NOP;
      last_k = PSP_NOP;
    end else if (!qual_n) begin
      if (hk[1] == PSP_WR)
        for (int i = 0; i < 4; i++) if (!hb[1][i]) mem[ha[1]][9*i+:9] = hd[1][9*i+:9];
      hk[1] = hk[0];
      ha[1] = ha[0];
      hb[1] = hb[0];
      hd[1] = hd[0];
      if (sleep) hk[0] = PSP_NOP;
      else if (adv) begin
        k = k + 2'h1;
        hk[0] = last_k;
        ha[0] = {base[AW-1:2], order ? base[1:0] ^ k : base[1:0] + k};
      end else begin
        k = 2'h0;
        base = addr;
        ha[0] = addr;
        hk[0] = (cs1_n | !cs2 | cs3_n) ? PSP_NOP : (ws_n ? PSP_RD : PSP_WR);
      end
      last_k = hk[0];
      hb[0] = be_n;
      hd[0] = cur_d;
    end
  end
  // data phase drive and output checks
  always @(negedge ref_clk) begin
    host_en <= (hk[1] == PSP_WR) && nrst;
    host_d <= hd[1];
    #1;
    check(DW'(dq_oe_n), DW'(!(hk[1] == PSP_RD && !oe_n && !sleep)));
    check(DW'(clash), '0);
    check(DW'(sleep_active), DW'(sl_q));
    if (hk[1] == PSP_RD) check(dq_out, mem[ha[1]]);
  end
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) nrst = 1;
    check(dq_out, '0);
    for (int i = 0; i < 24; i++) issue(1, AW'(i), 4'h0);
    for (int i = 0; i < 8; i++) issue(0, AW'(i), 4'h0);
    tag9 = 9'h1c3;
    for (int i = 0; i < 8; i++) begin
      issue(1, AW'(16 + i), 4'h0);
      issue(0, AW'(16 + i), 4'h0);
    end
    for (int b = 0; b < 16; b++) issue(1, AW'(b), b[3:0]);
    for (int b = 0; b < 16; b++) issue(0, AW'(b), 4'h0);
    for (int o = 0; o < 2; o++) begin
      tag9 = o[0] ? 9'h0f0 : 9'h13c;
      issue(1, 8'h21, 4'h0);
      order = o[0];
      repeat (3) issue(1, 8'hff, 4'h0, 1);
      issue(0, 8'h22, 4'h0);
      repeat (3) issue(0, 8'hff, 4'h0, 1);
    end
    tag9 = 9'h055;
    issue(1, 8'h40, 4'h0);
    issue(0, 8'h40, 4'h0);
    tag9 = 9'h1aa;
    repeat (3) issue(1, 8'h40, 4'h0, 0, 3'b010, 1);
    issue(0, 8'h40, 4'h0);
    for (int j = 0; j < 3; j++) issue(1, 8'h40, 4'h0, 0, j == 0 ? 3'b110 : (j == 1 ? 3'b000 : 3'b011));
    issue(0, 8'h40, 4'h0);
    oe_n = 1;
    repeat (2) issue(0, 8'h40, 4'h0);
    repeat (2) issue(0, 8'h00, 4'h0, 0, 3'b110);
    oe_n = 0;
    sleep = 1;
    issue(1, 8'h40, 4'h0);
    issue(0, 8'h40, 4'h0);
    repeat (2) issue(0, 8'h00, 4'h0, 0, 3'b110);
    sleep = 0;
    issue(0, 8'h40, 4'h0);
    repeat (4) issue(0, 8'h00, 4'h0, 0, 3'b110);
    give_verdict();
  end
endmodule : testbench
